// >>> rtl/blmi_defines.svh
// constants for the byte lane mask and inversion block
`ifndef BLMI_DEFINES_SVH
`define BLMI_DEFINES_SVH
`define BLMI_MODE3_WR_INV_BIT 7
`define BLMI_MODE3_RD_INV_BIT 6
`define BLMI_MODE13_MASK_BIT  5
`define BLMI_LANES            2
`define BLMI_RD_ONES_LIMIT    4'h4
`define BLMI_MW_ONES_LIMIT    3'h5
`define BLMI_FIFO_DEPTH       8
`define BLMI_TRAIN_DEPTH      16
`define BLMI_TRAIN_PTR_W      4
`define BLMI_CAL_PATTERN      16'h5a3c
`endif

// >>> rtl/blmi_pkg.sv
// types shared by the byte lane mask and inversion block
package blmi_pkg;
   // operation carried by one bit time at the link
   typedef enum logic [2:0] {
      BLMI_OP_WRITE   = 3'h0,
      BLMI_OP_MWRITE  = 3'h1,
      BLMI_OP_READ    = 3'h2,
      BLMI_OP_REGRD   = 3'h3,
      BLMI_OP_WRFIFO  = 3'h4,
      BLMI_OP_RDFIFO  = 3'h5,
      BLMI_OP_RDCAL   = 3'h6,
      BLMI_OP_IDLE    = 3'h7
   } blmi_op_e;

   // one received bit time: two byte lanes plus their pins
   typedef struct packed {
      logic [15:0] data;
      logic [1:0]  pin;
   } blmi_beat_s;

   // one written bit time toward the array
   typedef struct packed {
      logic [15:0] data;
      logic [1:0]  byte_en;
      logic [1:0]  train_pin;
      logic        train;
   } blmi_wbeat_s;
endpackage : blmi_pkg

// >>> rtl/blmi_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module blmi_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,      // core clock
   input  wire logic             reset,    // sync reset, active high
   input  wire logic [WIDTH-1:0] in_data,  // data in
   input  wire logic             in_valid, // data in valid
   output logic                  in_ready, // room available
   output logic      [WIDTH-1:0] out_data, // data out
   output logic                  out_valid,// data out valid
   input  wire logic             out_ready // drain side ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // full and empty come from the occupancy count
   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : blmi_fifo

// >>> rtl/blmi_lane.sv
// byte lane mask and inversion logic for one channel
`timescale 1ns/1ps
`include "blmi_defines.svh"
//
// What this block does
// - write inversion, plain and masked, follows mode register three bit 7
// - read inversion follows mode register three bit 6
// - masking for masked writes follows mode register thirteen bit 5
// - masking and inversion work per byte, one pin per byte, two per channel
// - pin is bidirectional, sampled or driven with its byte's data lines
// - with nothing applying, pin input is ignored and its receiver is off
// - read inversion off keeps pin drivers off on reads and register reads
// - plain write with inversion: pin high inverts byte, low stores it unchanged
// - read inversion: byte with more than four ones is inverted, pin high
// - masking on, inversion off: plain write never masked, pin held low
// - masked write, inversion off: pin high masks the byte's bit time
// - masked write both on: pin low and five ones in upper six masks
// - write fifo loading captures pin as training data, no mask or invert
// - read fifo drives pin with the pattern captured during loading
// - read calibration drives pin with a training pattern
// - register reads without inversion support drive the pin low
// - register reads with support invert bytes over four ones, pin high
//
module blmi_lane
   import blmi_pkg::*;
#(
   parameter bit REGRD_INV_SUPPORT = 1'b1  // register reads honour read inversion
) (
   input  wire logic              clk,           // core clock, 100 ns
   input  wire logic              reset,         // sync reset, active high
   input  wire logic              link_clk,      // bit-time clock at the link
   input  wire logic              link_reset,    // sync reset in link domain
   input  wire logic              wr_inv_en,     // mode register three bit 7
   input  wire logic              rd_inv_en,     // mode register three bit 6
   input  wire logic              mask_fn_en,    // mode register thirteen bit 5
   input  wire blmi_pkg::blmi_op_e link_op,      // operation of this bit time
   input  wire logic [15:0]       dq_in,         // data lines received
   input  wire logic [1:0]        pin_in,        // mask_invert_pin levels
   output logic      [15:0]       dq_out,        // data lines driven
   output logic                   dq_oe,         // data drivers on
   output logic      [1:0]        pin_out,       // mask_invert_pin drive
   output logic      [1:0]        pin_oe,        // mask_invert_pin drivers on
   output logic      [1:0]        pin_rx_en,     // pin receivers powered
   input  wire logic [15:0]       rd_data,       // read data for next bit time
   output blmi_pkg::blmi_wbeat_s  wr_beat,       // decoded write beat
   output logic                   wr_valid,      // write beat valid
   input  wire logic              wr_ready,      // array takes the beat
   output logic                   illegal_mw     // masked write while masking off
);
   // link-domain copies of the mode bits, two flops each
   logic [2:0]  mode_meta_reg;
   logic [2:0]  mode_sync_reg;
   logic        wr_inv;
   logic        rd_inv;
   logic        mask_en;
   logic        any_fn;
   logic [1:0]  train_reg [`BLMI_TRAIN_DEPTH];
   logic [`BLMI_TRAIN_PTR_W-1:0] train_wr_ptr_reg;
   logic [`BLMI_TRAIN_PTR_W-1:0] train_rd_ptr_reg;
   logic [`BLMI_TRAIN_PTR_W-1:0] cal_ptr_reg;
   blmi_wbeat_s beat_next;
   logic        beat_push;
   logic        illegal_next;
   logic [15:0] dq_next;
   logic [1:0]  pin_next;
   logic [1:0]  pin_oe_next;
   logic        dq_oe_next;
   logic        fifo_in_ready;
   logic [$bits(blmi_wbeat_s)-1:0] fifo_out;
   logic [15:0] cal_pat;

   // mode bits are quasi-static but cross into the link clock anyway
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         mode_meta_reg <= 3'h0;
         mode_sync_reg <= 3'h0;
      end else begin
         mode_meta_reg <= {wr_inv_en, rd_inv_en, mask_fn_en};
         mode_sync_reg <= mode_meta_reg;
      end
   end

   assign wr_inv  = mode_sync_reg[2];
   assign rd_inv  = mode_sync_reg[1];
   assign mask_en = mode_sync_reg[0];
   assign any_fn  = wr_inv || rd_inv || mask_en;

   // count of ones in a byte
   function automatic logic [3:0] ones8(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + 4'(b[i]);
      end
      return n;
   endfunction : ones8

   // ones in the upper six data lines of a byte
   function automatic logic [2:0] ones6(input logic [7:0] b);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 2; i < 8; i++) begin
         n = n + 3'(b[i]);
      end
      return n;
   endfunction : ones6

   // receivers only powered when the pin carries meaning on writes
   always_comb begin
      for (int l = 0; l < `BLMI_LANES; l++) begin
         pin_rx_en[l] = wr_inv || mask_en || (any_fn && link_op == BLMI_OP_WRFIFO);
      end
   end

   always_comb begin
      logic [7:0] b;
      logic       p;
      b = 8'h00;
      p = 1'b0;
      beat_next    = '0;
      beat_push    = 1'b0;
      illegal_next = 1'b0;
      unique case (link_op)
         BLMI_OP_WRITE: begin
            beat_push = 1'b1;
            for (int l = 0; l < `BLMI_LANES; l++) begin
               b = dq_in[l*8 +: 8];
               // pin ignored when write inversion is off
               p = pin_in[l] && wr_inv;
               // high pin inverts; plain write never masked
               beat_next.data[l*8 +: 8] = p ? ~b : b;
               beat_next.byte_en[l]     = 1'b1;
            end
         end
         BLMI_OP_MWRITE: begin
            // masked write with masking off is dropped as illegal
            illegal_next = !mask_en;
            beat_push    = mask_en;
            for (int l = 0; l < `BLMI_LANES; l++) begin
               b = dq_in[l*8 +: 8];
               p = pin_in[l];
               if (wr_inv) begin
                  // low pin with five or more ones masks
                  beat_next.byte_en[l]     = !(!p && ones6(b) >= `BLMI_MW_ONES_LIMIT);
                  beat_next.data[l*8 +: 8] = p ? ~b : b;
               end else begin
                  // high pin masks the bit time
                  beat_next.byte_en[l]     = !p;
                  beat_next.data[l*8 +: 8] = b;
               end
            end
         end
         BLMI_OP_WRFIFO: begin
            // pin kept as training data, data passes untouched
            beat_push         = 1'b1;
            beat_next.data    = dq_in;
            beat_next.byte_en = 2'h3;
            beat_next.train   = 1'b1;
            beat_next.train_pin = any_fn ? pin_in : 2'h0;
         end
         default: begin
            beat_push = 1'b0;
         end
      endcase
   end

   // training pattern store for the pins
   always_ff @(posedge link_clk) begin
      if (link_op == BLMI_OP_WRFIFO && any_fn) begin
         train_reg[train_wr_ptr_reg] <= pin_in;
      end
   end

   // training pointers; calibration pattern walks on its own index
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         train_wr_ptr_reg <= '0;
         train_rd_ptr_reg <= '0;
         cal_ptr_reg      <= '0;
      end else begin
         if (link_op == BLMI_OP_WRFIFO && any_fn) begin
            train_wr_ptr_reg <= train_wr_ptr_reg + 1'b1;
         end
         if (link_op == BLMI_OP_RDFIFO && any_fn) begin
            train_rd_ptr_reg <= train_rd_ptr_reg + 1'b1;
         end
         cal_ptr_reg <= (link_op == BLMI_OP_RDCAL) ? cal_ptr_reg + 1'b1 : '0;
      end
   end

   // pattern held as a signal so one bit of it feeds both pins
   assign cal_pat = `BLMI_CAL_PATTERN;

   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      dq_next     = rd_data;
      pin_next    = 2'h0;
      pin_oe_next = 2'h0;
      dq_oe_next  = 1'b0;
      unique case (link_op)
         BLMI_OP_READ, BLMI_OP_REGRD: begin
            dq_oe_next = 1'b1;
            // drivers stay off without read inversion
            pin_oe_next = rd_inv ? 2'h3 : 2'h0;
            if (rd_inv && (link_op == BLMI_OP_READ || REGRD_INV_SUPPORT)) begin
               for (int l = 0; l < `BLMI_LANES; l++) begin
                  b = rd_data[l*8 +: 8];
                  if (ones8(b) > `BLMI_RD_ONES_LIMIT) begin
                     dq_next[l*8 +: 8] = ~b;
                     pin_next[l]       = 1'b1;
                  end
               end
            end
         end
         BLMI_OP_RDFIFO: begin
            dq_oe_next  = 1'b1;
            pin_oe_next = any_fn ? 2'h3 : 2'h0;
            pin_next    = any_fn ? train_reg[train_rd_ptr_reg] : 2'h0;
         end
         BLMI_OP_RDCAL: begin
            dq_oe_next  = 1'b1;
            pin_oe_next = any_fn ? 2'h3 : 2'h0;
            pin_next    = any_fn ? {2{cal_pat[cal_ptr_reg]}} : 2'h0;
         end
         default: begin
            dq_oe_next = 1'b0;
         end
      endcase
   end

   // pin and data drive registered together in one bit time
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         dq_out  <= 16'h0000;
         dq_oe   <= 1'b0;
         pin_out <= 2'h0;
         pin_oe  <= 2'h0;
      end else begin
         dq_out  <= dq_next;
         dq_oe   <= dq_oe_next;
         pin_out <= pin_next;
         pin_oe  <= pin_oe_next;
      end
   end

   // illegal flag is a one-bit-time pulse in the link domain
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         illegal_mw <= 1'b0;
      end else begin
         illegal_mw <= illegal_next;
      end
   end

   // write beats cross to the core clock through a two-flop synchronised toggle handoff:
   // a small async fifo would be ideal; here a toggle handshake carries beats
   logic [$bits(blmi_wbeat_s)-1:0] hold_reg;
   logic hold_tgl_reg;
   logic ack_meta_reg;
   logic ack_sync_reg;
   logic busy;
   logic req_meta_reg;
   logic req_sync_reg;
   logic req_seen_reg;
   logic ack_tgl_reg;
   logic xfer_valid;

   // link side only accepts a beat when the last one was acknowledged
   assign busy = (hold_tgl_reg != ack_sync_reg);

   // link side capture; beats arriving while busy are lost, controller must pace
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         hold_reg     <= '0;
         hold_tgl_reg <= 1'b0;
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end else begin
         ack_meta_reg <= ack_tgl_reg;
         ack_sync_reg <= ack_meta_reg;
         if (beat_push && !busy) begin
            hold_reg     <= beat_next;
            hold_tgl_reg <= !hold_tgl_reg;
         end
      end
   end

   // core side detects a new beat and loads it into the fifo
   assign xfer_valid = (req_sync_reg != req_seen_reg);
   always_ff @(posedge clk) begin
      if (reset) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         req_seen_reg <= 1'b0;
         ack_tgl_reg  <= 1'b0;
      end else begin
         req_meta_reg <= hold_tgl_reg;
         req_sync_reg <= req_meta_reg;
         if (xfer_valid && fifo_in_ready) begin
            req_seen_reg <= req_sync_reg;
            ack_tgl_reg  <= req_sync_reg;
         end
      end
   end

   // buffer before the array; array stall fills it and holds the handshake
   blmi_fifo #(
      .WIDTH ($bits(blmi_wbeat_s)),
      .DEPTH (`BLMI_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_data   (hold_reg),
      .in_valid  (xfer_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (wr_valid),
      .out_ready (wr_ready)
   );
   assign wr_beat = blmi_wbeat_s'(fifo_out);

   // inverted read byte always drives the pin high next bit time
   chk_rd_inv_pin: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_READ && rd_inv && ones8(rd_data[7:0]) > `BLMI_RD_ONES_LIMIT)
      |=> (pin_out[0] && pin_oe[0] && dq_out[7:0] == ~$past(rd_data[7:0])))
      else $error("read inversion pin wrong");
   // no pin drive on reads without read inversion
   chk_rd_off: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_READ && !rd_inv) |=> (pin_oe == 2'h0))
      else $error("pin driven with read inversion off");
   // receivers off when nothing uses the pin
   chk_rx_off: assert property (@(posedge link_clk) disable iff (link_reset)
      (!wr_inv && !mask_en && link_op != BLMI_OP_WRFIFO) |-> (pin_rx_en == 2'h0))
      else $error("receiver on without use");
   // masked write with high pin disables the byte
   chk_mask_hi: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_MWRITE && mask_en && !wr_inv && pin_in[0])
      |-> !beat_next.byte_en[0])
      else $error("high pin did not mask");
   // low pin with five ones masks under inversion
   chk_mask_five: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_MWRITE && mask_en && wr_inv && !pin_in[1]
       && ones6(dq_in[15:8]) >= `BLMI_MW_ONES_LIMIT) |-> !beat_next.byte_en[1])
      else $error("five ones not masked");
   // plain write high pin inverts byte
   chk_wr_inv: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_WRITE && wr_inv && pin_in[0])
      |-> beat_next.data[7:0] == ~dq_in[7:0])
      else $error("write data not inverted");
   // plain write always enables both bytes
   chk_wr_nomask: assert property (@(posedge link_clk) disable iff (link_reset)
      link_op == BLMI_OP_WRITE |-> beat_next.byte_en == 2'h3)
      else $error("plain write masked");
   // register read pin low without read inversion or its support
   chk_regrd_low: assert property (@(posedge link_clk) disable iff (link_reset)
      (link_op == BLMI_OP_REGRD && (!rd_inv || !REGRD_INV_SUPPORT)) |=> pin_out == 2'h0)
      else $error("register read pin not low");
endmodule : blmi_lane

// >>> tb/blmi_ctrl_model.sv
// behavioural controller at the far side of the link, one bit time per call
`timescale 1ns/1ps
module blmi_ctrl_model
   import blmi_pkg::*;
(
   input  wire logic               link_clk, // bit-time clock
   output blmi_pkg::blmi_op_e      link_op,  // operation of this bit time
   output logic [15:0]             dq_in,    // data lines toward the device
   output logic [1:0]              pin_in,   // resolved mask_invert_pin level
   output logic [15:0]             rd_data,  // array data for a read bit time
   input  wire logic [1:0]         pin_out,  // device pin drive
   input  wire logic [1:0]         pin_oe    // device pin drivers on
);
   logic [1:0] pin_drv;

   // the two-way pin: the device wins only where its driver is on
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);

   initial begin
      link_op = BLMI_OP_IDLE;
      dq_in   = 16'h0;
      pin_drv = 2'h0;
      rd_data = 16'h0;
   end

   // one bit time: pin and data change together, then are released
   task automatic send(input blmi_op_e op, input logic [15:0] dq, input logic [1:0] pin,
                       input logic [15:0] rd);
      @(negedge link_clk);
      link_op <= op;
      dq_in   <= dq;
      pin_drv <= pin;
      rd_data <= rd;
      @(negedge link_clk);
      // released lines show the inverse, so a stale copy is never mistaken for data
      link_op <= BLMI_OP_IDLE;
      dq_in   <= ~dq;
      pin_drv <= ~pin;
      rd_data <= ~rd;
   endtask : send
endmodule : blmi_ctrl_model

// >>> tb/test_byte_lane_mask_and_inversion.sv
// self-checking bench for the byte lane mask and inversion block
`timescale 1ns/1ps
module test_byte_lane_mask_and_inversion
   import blmi_pkg::*;
;
   logic        clk, reset, link_clk, link_reset, wr_ready, hold, ill_seen;
   logic        wr_inv_en, rd_inv_en, mask_fn_en, dq_oe, wr_valid, illegal_mw;
   blmi_op_e    link_op;
   logic [15:0] dq_in, dq_out, rd_data;
   logic [1:0]  pin_in, pin_out, pin_oe, pin_rx_en;
   blmi_wbeat_s wr_beat, mon_exp;
   blmi_wbeat_s exp_q[$];
   logic [1:0]  pat[16];
   int          n_mismatch, n_checks, cyc;
   blmi_op_e    ops[7] = '{BLMI_OP_READ, BLMI_OP_REGRD, BLMI_OP_RDCAL, BLMI_OP_RDFIFO,
                           BLMI_OP_WRITE, BLMI_OP_MWRITE, BLMI_OP_WRFIFO};

   blmi_lane dut (.clk(clk), .reset(reset), .link_clk(link_clk), .link_reset(link_reset),
      .wr_inv_en(wr_inv_en), .rd_inv_en(rd_inv_en), .mask_fn_en(mask_fn_en),
      .link_op(link_op), .dq_in(dq_in), .pin_in(pin_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_rx_en(pin_rx_en), .rd_data(rd_data),
      .wr_beat(wr_beat), .wr_valid(wr_valid), .wr_ready(wr_ready), .illegal_mw(illegal_mw));

   blmi_ctrl_model u_ctrl (.link_clk(link_clk), .link_op(link_op), .dq_in(dq_in),
      .pin_in(pin_in), .rd_data(rd_data), .pin_out(pin_out), .pin_oe(pin_oe));

   // core clock 100 ns, link clock 15 ns with an unrelated phase
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #7.5 link_clk = ~link_clk;
   end

   task automatic check(input bit ok, input string msg);
      n_checks++;
      if (!ok) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   function automatic int ones(input logic [7:0] x);
      ones = 0;
      for (int i = 0; i < 8; i++) ones += int'(x[i]);
   endfunction : ones

   // read data as it should leave the lane: {pin, dq}
   function automatic logic [17:0] exp_rd(input logic [15:0] rd);
      logic [17:0] r;
      r = {2'h0, rd};
      for (int i = 0; i < 2; i++) begin
         if (rd_inv_en && ones(rd[8*i +: 8]) > 4) begin
            r[8*i +: 8] = ~rd[8*i +: 8];
            r[16+i] = 1'b1;
         end
      end
      return r;
   endfunction : exp_rd

   function automatic blmi_wbeat_s exp_wr(input blmi_op_e op, input logic [15:0] dq,
                                          input logic [1:0] pin);
      blmi_wbeat_s b;
      logic [7:0]  x;
      b.data = dq;
      b.byte_en = 2'h3;
      b.train_pin = pin;
      b.train = (op == BLMI_OP_WRFIFO);
      for (int i = 0; i < 2; i++) begin
         x = dq[8*i +: 8];
         if (op == BLMI_OP_MWRITE && pin[i] == !wr_inv_en
             && (!wr_inv_en || ones({2'h0, x[7:2]}) >= 5)) b.byte_en[i] = 1'b0;
         else if (!b.train && wr_inv_en && pin[i]) b.data[8*i +: 8] = ~x;
      end
      return b;
   endfunction : exp_wr

   task automatic set_mode(input logic [2:0] m);
      @(negedge link_clk);
      {wr_inv_en, rd_inv_en, mask_fn_en} = m;
      repeat (4) @(negedge link_clk);
   endtask : set_mode

   // one bit time, then the checks that belong to its kind
   task automatic do_op(input blmi_op_e op, input logic [15:0] dq, input logic [1:0] pin,
                        input logic [15:0] rd);
      logic [17:0] e;
      ill_seen = 1'b0;
      e = exp_rd(rd);
      u_ctrl.send(op, dq, pin, rd);
      if (op == BLMI_OP_READ || op == BLMI_OP_REGRD) begin
         check(dq_out === e[15:0] && dq_oe === 1'b1 && pin_oe === {2{rd_inv_en}}
               && (!rd_inv_en || pin_out === e[17:16]), "read lane");
      end else if (op == BLMI_OP_RDCAL || op == BLMI_OP_RDFIFO) begin
         check(pin_oe === {2{wr_inv_en | rd_inv_en | mask_fn_en}}, "training drive");
         if (op == BLMI_OP_RDCAL && pin_oe[0]) check(pin_out[0] === pin_out[1], "cal pin");
      end else begin
         if (op != BLMI_OP_MWRITE || mask_fn_en) exp_q.push_back(exp_wr(op, dq, pin));
         // writes are paced so the previous beat has left the handoff
         repeat (30) @(negedge link_clk);
         check(ill_seen === (op == BLMI_OP_MWRITE && !mask_fn_en), "masked write flag");
      end
   endtask : do_op

   // wait, within a bound, until every expected beat has reached the array
   task automatic drain();
      repeat (300) begin
         @(negedge clk);
         if (exp_q.size() == 0) break;
      end
   endtask : drain

   // beats at the array match the decoding
   always @(posedge clk) begin
      if (!reset && wr_valid === 1'b1 && wr_ready) begin
         if (exp_q.size() == 0) check(1'b0, "unexpected write beat");
         else begin
            mon_exp = exp_q.pop_front();
            check(wr_beat.train === mon_exp.train && wr_beat.byte_en === mon_exp.byte_en
               && (!mon_exp.byte_en[0] || wr_beat.data[7:0] === mon_exp.data[7:0])
               && (!mon_exp.byte_en[1] || wr_beat.data[15:8] === mon_exp.data[15:8])
               && (!mon_exp.train || wr_beat.train_pin === mon_exp.train_pin), "write beat");
         end
      end
   end

   always @(posedge link_clk) begin
      if (illegal_mw === 1'b1) ill_seen <= 1'b1;
      if ((link_op == BLMI_OP_WRITE && !wr_inv_en && !mask_fn_en) ||
          (link_op == BLMI_OP_WRFIFO && !(wr_inv_en | rd_inv_en | mask_fn_en)))
         check(pin_rx_en === 2'h0, "pin receivers on");
   end

   // array side stalls at random, or fully while the buffer is being filled
   always @(negedge clk) wr_ready <= hold ? 1'b0 : 1'($urandom);

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      blmi_op_e   op;
      logic [1:0] pin;
      void'($urandom(32'hff3bd02e));
      {wr_inv_en, rd_inv_en, mask_fn_en} = 3'h0;
      {hold, ill_seen, wr_ready, cyc, n_mismatch, n_checks} = '0;
      reset = 1'b1;
      link_reset = 1'b1;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      @(negedge link_clk) link_reset = 1'b0;
      check(pin_oe === 2'h0 && dq_oe === 1'b0 && wr_valid === 1'b0, "not quiet after reset");
      // training store first, while its pointers sit at the reset place
      set_mode(3'h7);
      for (int i = 0; i < 16; i++) begin
         pat[i] = 2'($urandom);
         do_op(BLMI_OP_WRFIFO, 16'($urandom), pat[i], 16'h0);
      end
      for (int i = 0; i < 16; i++) begin
         do_op(BLMI_OP_RDFIFO, 16'h0, 2'h0, 16'h0);
         check(pin_out === pat[i], "read fifo pattern");
      end
      for (int m = 0; m < 8; m++) begin
         set_mode(3'(m));
         // corners: four against five ones, and a lane with five ones only above bit 2
         do_op(BLMI_OP_READ, 16'h0, 2'h0, 16'h1f0f);
         do_op(BLMI_OP_REGRD, 16'h0, 2'h0, 16'hf0e1);
         do_op(BLMI_OP_MWRITE, 16'hf3f8, 2'h0, 16'h0);
         do_op(BLMI_OP_MWRITE, 16'h5a5a, 2'h2, 16'h0);
         for (int k = 0; k < 12; k++) begin
            op = ops[$urandom % 7];
            pin = 2'($urandom);
            if (op == BLMI_OP_MWRITE && !mask_fn_en) op = BLMI_OP_WRITE;
            if (op == BLMI_OP_WRFIFO && m == 0) op = BLMI_OP_WRITE;
            if (op == BLMI_OP_WRITE && mask_fn_en && !wr_inv_en) pin = 2'h0;
            do_op(op, 16'($urandom), pin, 16'($urandom));
         end
      end
      // empty the buffer first so exactly 8 stalled beats fit, then fill and drain it
      drain();
      hold = 1'b1;
      set_mode(3'h4);
      for (int k = 0; k < 8; k++) do_op(BLMI_OP_WRITE, 16'($urandom), 2'($urandom), 16'h0);
      check(wr_valid === 1'b1, "buffer not holding beats");
      hold = 1'b0;
      drain();
      check(exp_q.size() == 0, "write beats lost");
      give_verdict();
   end
endmodule : test_byte_lane_mask_and_inversion
